// *** ccd_decoder.sv ***
// Our own choice: the plain strobed port.
module ccd_decoder
  import ccd_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  input  wire logic         h_mode,
  input  wire logic         conn_ready,
  input  wire logic         ref_fail,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [7:0]   reg_rdata,
  output logic      [7:0]   source_port_address,
  output logic      [7:0]   input_slot_address,
  output logic      [7:0]   destination_port_address,
  output logic      [7:0]   output_slot_address,
  output logic              backplane_master,
  output logic      [3:0]   primary_ref_sel,
  output logic      [2:0]   primary_ref_freq,
  output logic      [3:0]   secondary_ref_sel,
  output logic      [2:0]   secondary_ref_freq,
  output logic      [3:0]   slave_src_sel,
  output logic              special_prog,
  output logic      [7:0]   special_cfg,
  output logic      [1:0]   backplane_out_sel,
  output logic              pcm_clk_en,
  output logic      [2:0]   pcm_clk_rate,
  output logic              pcm_clk_out,
  output logic              compat_first_en,
  output logic              compat_second_en,
  output logic      [1:0]   serial_bus_sel,
  output logic      [2:0]   netref_one_sel,
  output logic              netref_one_inv,
  output logic      [1:0]   netref_one_freq,
  output logic      [2:0]   netref_two_sel,
  output logic              netref_two_inv,
  output logic      [1:0]   netref_two_freq,
  output logic      [1:0]   fallback_mode,
  output logic              refallback_en,
  output logic              phase_align_en,
  output logic              pll_src_fail,
  output logic              ref_src_fail,
  output logic      [63:0]  local_in_rates,
  output logic      [63:0]  local_out_rates,
  output logic      [63:0]  bp_line_rates,
  output logic              disconnect_all,
  output logic              bidir_connect,
  output logic              bidir_const_delay,
  output logic              dump_en,
  output logic              ts_read_req,
  output logic              ts_read_output
);

  // ****************************************
  // decoding helpers
  // ****************************************
  // primary reference value legal in the present mode
  function automatic logic primary_ok(input logic [3:0] q,
                                      input logic       h);
    unique case (q)
      4'h0, 4'h5, 4'h6:      primary_ok = 1'b1;
      4'h1, 4'h2:            primary_ok = !h;
      4'h9, 4'hA:            primary_ok = 1'b0;
      default:               primary_ok = h;
    endcase
  endfunction

  // write strobe aimed at one register
  function automatic logic wr_hit(input logic [7:0] a,
                                  input logic [7:0] ofs);
    wr_hit = reg_wr && (a == ofs);
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [7:0] spa_r, spa_nxt, input_slot_address_r, input_slot_address_nxt;
  logic [7:0] dpa_r, dpa_nxt, output_slot_address_r, output_slot_address_nxt;
  logic [7:0] gi1_r, gi1_nxt, connection_command_r, connection_command_nxt;
  logic [7:0] cmd_r, cmd_nxt, rdata_r, rdata_nxt;
  logic       master_r, master_nxt;
  logic [3:0] prim_r, prim_nxt, sec_r, sec_nxt;
  logic [2:0] pfreq_r, pfreq_nxt, sfreq_r, sfreq_nxt;
  logic [3:0] slave_r, slave_nxt;
  logic       sprog_r, sprog_nxt;
  logic [7:0] scfg_r, scfg_nxt;
  logic [1:0] bpo_r, bpo_nxt;
  logic       pen_r, pen_nxt, pout_r, pout_nxt;
  logic [2:0] prate_r, prate_nxt;
  logic       c1_r, c1_nxt, c2_r, c2_nxt;
  logic [1:0] sbus_r, sbus_nxt;
  logic [2:0] nr1_r, nr1_nxt, nr2_r, nr2_nxt;
  logic       ni1_r, ni1_nxt, ni2_r, ni2_nxt;
  logic [1:0] nf1_r, nf1_nxt, nf2_r, nf2_nxt;
  logic [1:0] fb_r, fb_nxt;
  logic       rfb_r, rfb_nxt, pa_r, pa_nxt;
  logic       pllf_r, pllf_nxt, reff_r, reff_nxt;
  logic [1:0] inr_r  [NUM_LINES];
  logic [1:0] inr_nxt[NUM_LINES];
  logic [1:0] outr_r  [NUM_LINES];
  logic [1:0] outr_nxt[NUM_LINES];
  logic [1:0] bpr_r  [NUM_LINES];
  logic [1:0] bpr_nxt[NUM_LINES];
  logic       dis_r, dis_nxt, bid_r, bid_nxt;
  logic       bcd_r, bcd_nxt, dump_r, dump_nxt;
  logic       tsr_r, tsr_nxt, tso_r, tso_nxt;

  logic [3:0] code, qual, ccode, cqual;
  logic       cmd_go, conn_go;

  // the executed command is the written byte itself, so one write taken with clk_en high is
  // exactly one execution and a later read cannot re-trigger it
  assign code    = reg_wdata[3:0];
  assign qual    = reg_wdata[7:4];
  assign ccode   = reg_wdata[3:0];
  assign cqual   = reg_wdata[7:4];
  assign cmd_go  = wr_hit(reg_addr, OFS_CLK_CMD);
  assign conn_go = wr_hit(reg_addr, OFS_CONN_CMD);

  // ****************************************
  // host registers and read port
  // ****************************************
  always_comb begin
    spa_nxt  = wr_hit(reg_addr, OFS_SRC_PORT) ? reg_wdata : spa_r;
    input_slot_address_nxt = wr_hit(reg_addr, OFS_IN_SLOT)  ? reg_wdata : input_slot_address_r;
    dpa_nxt  = wr_hit(reg_addr, OFS_DST_PORT) ? reg_wdata : dpa_r;
    output_slot_address_nxt = wr_hit(reg_addr, OFS_OUT_SLOT) ? reg_wdata : output_slot_address_r;
    gi1_nxt  = wr_hit(reg_addr, OFS_GEN_IN1)  ? reg_wdata : gi1_r;
    connection_command_nxt = conn_go ? reg_wdata : connection_command_r;
    cmd_nxt  = cmd_go  ? reg_wdata : cmd_r;
    rdata_nxt = RST_BYTE;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_SRC_PORT:   rdata_nxt = spa_r;
        OFS_IN_SLOT:    rdata_nxt = input_slot_address_r;
        OFS_DST_PORT:   rdata_nxt = dpa_r;
        OFS_OUT_SLOT:   rdata_nxt = output_slot_address_r;
        OFS_GEN_IN1:    rdata_nxt = gi1_r;
        OFS_CONN_CMD:   rdata_nxt = connection_command_r;
        OFS_CLK_CMD:    rdata_nxt = cmd_r;
        OFS_STATUS: begin
          rdata_nxt[ST_READY_BIT] = conn_ready;
          rdata_nxt[ST_DUMP_BIT]  = dump_r;
        end
        OFS_ERR_STATUS: begin
          rdata_nxt[ERR_REF_BIT] = reff_r;
          rdata_nxt[ERR_PLL_BIT] = pllf_r;
        end
        default:        rdata_nxt = RST_BYTE;  // unmapped reads zero
      endcase
    end
  end

  // ****************************************
  // clock configuration command decode
  // ****************************************
  always_comb begin
    master_nxt = master_r;
    prim_nxt = prim_r;
    pfreq_nxt = pfreq_r;
    sec_nxt = sec_r;
    sfreq_nxt = sfreq_r;
    slave_nxt = slave_r;
    sprog_nxt = sprog_r;
    scfg_nxt = scfg_r;
    bpo_nxt = bpo_r;
    pen_nxt = pen_r;
    pout_nxt = pout_r;
    prate_nxt = prate_r;
    c1_nxt = c1_r;
    c2_nxt = c2_r;
    sbus_nxt = sbus_r;
    nr1_nxt = nr1_r;
    ni1_nxt = ni1_r;
    nf1_nxt = nf1_r;
    nr2_nxt = nr2_r;
    ni2_nxt = ni2_r;
    nf2_nxt = nf2_r;
    fb_nxt = fb_r;
    rfb_nxt = rfb_r;
    pa_nxt = pa_r;
    tsr_nxt = 1'b0;
    tso_nxt = tso_r;
    inr_nxt = inr_r;
    outr_nxt = outr_r;
    bpr_nxt = bpr_r;
    if (cmd_go) begin
      unique case (code)
        CC_MASTER: if (h_mode) master_nxt = qual[0];
        CC_PRIMARY: if (primary_ok(qual, h_mode)) begin
          prim_nxt = qual;
          // backplane pairs carry their own rate
          if (qual != 4'h7 && qual != 4'h8)
            pfreq_nxt = gi1_r[2:0];
        end
        CC_SECONDARY: if (h_mode) begin
          if (qual == Q_SPECIAL) begin
            sprog_nxt = 1'b1;
          end else begin
            sec_nxt   = qual;
            sfreq_nxt = gi1_r[2:0];
          end
        end
        CC_SLAVE: if (h_mode) begin
          if (qual == Q_SPECIAL) begin
            scfg_nxt  = gi1_r;
            sprog_nxt = 1'b0;
          end else if (qual >= 4'h5 && qual <= 4'hC) begin
            slave_nxt = qual;
          end
        end
        // value 11 is undefined, and bits 3..2 must stay zero
        CC_BP_OUT:
          if (h_mode && qual[3:2] == 2'h0 && qual[1:0] != 2'h3)
            bpo_nxt = qual[1:0];
        CC_PCM_CLK:
          if (qual[2:0] != 3'h0 && qual[2:0] <= 3'h4) begin
            pen_nxt   = 1'b1;
            prate_nxt = qual[2:0];
            pout_nxt  = qual[3];
          end
        CC_COMPAT: if (h_mode) begin
          c1_nxt   = qual[0];
          c2_nxt   = qual[1];
          sbus_nxt = qual[3:2];
        end
        CC_NETREF1: if (h_mode && qual[3:1] <= 3'h4) begin
          nr1_nxt = qual[3:1];
          ni1_nxt = qual[0];
          if (qual[3:1] == 3'h4) nf1_nxt = gi1_r[1:0];
        end
        CC_NETREF2: if (h_mode && qual[3:1] <= 3'h4) begin
          nr2_nxt = qual[3:1];
          ni2_nxt = qual[0];
          if (qual[3:1] == 3'h4) nf2_nxt = gi1_r[1:0];
        end
        CC_FALLBACK: begin
          if (h_mode) begin
            fb_nxt  = qual[1:0];
            rfb_nxt = qual[2];
          end
          pa_nxt = qual[3];
        end
        CC_RATE_LOC: begin
          if (qual[2]) inr_nxt[spa_r[4:0]] = qual[1:0];
          if (qual[3]) outr_nxt[dpa_r[4:0]] = qual[1:0];
        end
        CC_RATE_BP: begin
          if (qual[1:0] == 2'h3) begin
            for (int i = 0; i < NUM_LINES; i++)
              bpr_nxt[i] = RATE_8M;
          end else begin
            bpr_nxt[spa_r[4:0]] = qual[1:0];
          end
        end
        CC_READ_TS: begin
          tsr_nxt = 1'b1;
          tso_nxt = qual[0];
        end
        default: ;  // no operation and unassigned codes
      endcase
    end
  end

  // ****************************************
  // connection command decode
  // ****************************************
  // only the last three connection codes live here; the request
  // lines are one-cycle pulses to the switching core
  always_comb begin
    dis_nxt  = 1'b0;
    bid_nxt  = 1'b0;
    bcd_nxt  = bcd_r;
    dump_nxt = dump_r;
    if (conn_go) begin
      unique case (ccode)
        CN_DISC_ALL: dis_nxt = 1'b1;
        CN_BIDIR: begin
          bid_nxt = 1'b1;
          bcd_nxt = cqual[0];
        end
        CN_DUMP:     dump_nxt = cqual[0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // fallback failure flags
  // ****************************************
  // flags follow the failing clock while fallback is armed and drop
  // once it is valid again, so no software clear can lose an event
  always_comb begin
    reff_nxt = (fb_r != 2'h0) && ref_fail;
    pllf_nxt = (fb_r != 2'h0) && ref_fail;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      spa_r <= RST_BYTE;
      input_slot_address_r <= RST_BYTE;
      dpa_r <= RST_BYTE;
      output_slot_address_r <= RST_BYTE;
      gi1_r <= RST_BYTE;
      connection_command_r <= RST_BYTE;
      cmd_r <= RST_BYTE;
      rdata_r <= RST_BYTE;
      master_r <= 1'b0;
      prim_r <= 4'h0;
      pfreq_r <= 3'h0;
      sec_r <= 4'h0;
      sfreq_r <= 3'h0;
      slave_r <= 4'h0;
      sprog_r <= 1'b0;
      scfg_r <= RST_BYTE;
      bpo_r <= 2'h0;
      pen_r <= 1'b0;
      pout_r <= 1'b0;
      prate_r <= 3'h0;
      c1_r <= 1'b0;
      c2_r <= 1'b0;
      sbus_r <= 2'h0;
      nr1_r <= 3'h0;
      ni1_r <= 1'b0;
      nf1_r <= 2'h0;
      nr2_r <= 3'h0;
      ni2_r <= 1'b0;
      nf2_r <= 2'h0;
      fb_r <= 2'h0;
      rfb_r <= 1'b0;
      pa_r <= 1'b0;
      pllf_r <= 1'b0;
      reff_r <= 1'b0;
      dis_r <= 1'b0;
      bid_r <= 1'b0;
      bcd_r <= 1'b0;
      dump_r <= 1'b0;
      tsr_r <= 1'b0;
      tso_r <= 1'b0;
      for (int i = 0; i < NUM_LINES; i++) begin
        inr_r[i] <= RATE_2M;
        outr_r[i] <= RATE_2M;
        bpr_r[i] <= RATE_2M;
      end
    end else if (clk_en) begin
      spa_r <= spa_nxt;
      input_slot_address_r <= input_slot_address_nxt;
      dpa_r <= dpa_nxt;
      output_slot_address_r <= output_slot_address_nxt;
      gi1_r <= gi1_nxt;
      connection_command_r <= connection_command_nxt;
      cmd_r <= cmd_nxt;
      rdata_r <= rdata_nxt;
      master_r <= master_nxt;
      prim_r <= prim_nxt;
      pfreq_r <= pfreq_nxt;
      sec_r <= sec_nxt;
      sfreq_r <= sfreq_nxt;
      slave_r <= slave_nxt;
      sprog_r <= sprog_nxt;
      scfg_r <= scfg_nxt;
      bpo_r <= bpo_nxt;
      pen_r <= pen_nxt;
      pout_r <= pout_nxt;
      prate_r <= prate_nxt;
      c1_r <= c1_nxt;
      c2_r <= c2_nxt;
      sbus_r <= sbus_nxt;
      nr1_r <= nr1_nxt;
      ni1_r <= ni1_nxt;
      nf1_r <= nf1_nxt;
      nr2_r <= nr2_nxt;
      ni2_r <= ni2_nxt;
      nf2_r <= nf2_nxt;
      fb_r <= fb_nxt;
      rfb_r <= rfb_nxt;
      pa_r <= pa_nxt;
      pllf_r <= pllf_nxt;
      reff_r <= reff_nxt;
      dis_r <= dis_nxt;
      bid_r <= bid_nxt;
      bcd_r <= bcd_nxt;
      dump_r <= dump_nxt;
      tsr_r <= tsr_nxt;
      tso_r <= tso_nxt;
      inr_r <= inr_nxt;
      outr_r <= outr_nxt;
      bpr_r <= bpr_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // line rate tables flattened, line n in bits 2n+1..2n
  for (genvar g = 0; g < NUM_LINES; g++) begin : g_rates
    assign local_in_rates[2*g +: 2]  = inr_r[g];
    assign local_out_rates[2*g +: 2] = outr_r[g];
    assign bp_line_rates[2*g +: 2]   = bpr_r[g];
  end

  assign reg_rdata                = rdata_r;
  assign source_port_address      = spa_r;
  assign input_slot_address       = input_slot_address_r;
  assign destination_port_address = dpa_r;
  assign output_slot_address      = output_slot_address_r;
  assign backplane_master         = master_r;
  assign primary_ref_sel          = prim_r;
  assign primary_ref_freq         = pfreq_r;
  assign secondary_ref_sel        = sec_r;
  assign secondary_ref_freq       = sfreq_r;
  assign slave_src_sel            = slave_r;
  assign special_prog             = sprog_r;
  assign special_cfg              = scfg_r;
  assign backplane_out_sel        = bpo_r;
  assign pcm_clk_en               = pen_r;
  assign pcm_clk_rate             = prate_r;
  assign pcm_clk_out              = pout_r;
  assign compat_first_en          = c1_r;
  assign compat_second_en         = c2_r;
  assign serial_bus_sel           = sbus_r;
  assign netref_one_sel           = nr1_r;
  assign netref_one_inv           = ni1_r;
  assign netref_one_freq          = nf1_r;
  assign netref_two_sel           = nr2_r;
  assign netref_two_inv           = ni2_r;
  assign netref_two_freq          = nf2_r;
  assign fallback_mode            = fb_r;
  assign refallback_en            = rfb_r;
  assign phase_align_en           = pa_r;
  assign pll_src_fail             = pllf_r;
  assign ref_src_fail             = reff_r;
  assign disconnect_all           = dis_r;
  assign bidir_connect            = bid_r;
  assign bidir_const_delay        = bcd_r;
  assign dump_en                  = dump_r;
  assign ts_read_req              = tsr_r;
  assign ts_read_output           = tso_r;

endmodule

// *** ccd_pkg.sv ***
package ccd_pkg;
  // ****************************************
  // register offsets and reset byte
  // ****************************************
  localparam logic [7:0] OFS_SRC_PORT   = 8'h00;
  localparam logic [7:0] OFS_IN_SLOT    = 8'h01;
  localparam logic [7:0] OFS_DST_PORT   = 8'h02;
  localparam logic [7:0] OFS_OUT_SLOT   = 8'h03;
  localparam logic [7:0] OFS_GEN_IN1    = 8'h04;
  localparam logic [7:0] OFS_CONN_CMD   = 8'h06;
  localparam logic [7:0] OFS_CLK_CMD    = 8'h08;
  localparam logic [7:0] OFS_STATUS     = 8'h0E;
  localparam logic [7:0] OFS_ERR_STATUS = 8'h11;
  localparam logic [7:0] RST_BYTE       = 8'h00;
  // ****************************************
  // status field positions
  // ****************************************
  localparam int ST_READY_BIT = 0;
  localparam int ST_DUMP_BIT  = 1;
  localparam int ERR_REF_BIT  = 0;
  localparam int ERR_PLL_BIT  = 6;
  // ****************************************
  // command codes, qualifier, line rates and line count
  // ****************************************
  localparam logic [3:0] CC_NOP       = 4'h0;
  localparam logic [3:0] CC_MASTER    = 4'h1;
  localparam logic [3:0] CC_PRIMARY   = 4'h2;
  localparam logic [3:0] CC_SECONDARY = 4'h3;
  localparam logic [3:0] CC_SLAVE     = 4'h4;
  localparam logic [3:0] CC_BP_OUT    = 4'h5;
  localparam logic [3:0] CC_PCM_CLK   = 4'h6;
  localparam logic [3:0] CC_COMPAT    = 4'h7;
  localparam logic [3:0] CC_NETREF1   = 4'h8;
  localparam logic [3:0] CC_NETREF2   = 4'h9;
  localparam logic [3:0] CC_FALLBACK  = 4'hA;
  localparam logic [3:0] CC_RATE_LOC  = 4'hB;
  localparam logic [3:0] CC_RATE_BP   = 4'hC;
  localparam logic [3:0] CC_READ_TS   = 4'hD;
  localparam logic [3:0] CN_DISC_ALL  = 4'h8;
  localparam logic [3:0] CN_BIDIR     = 4'h9;
  localparam logic [3:0] CN_DUMP      = 4'hA;
  localparam logic [3:0] Q_SPECIAL    = 4'hF;
  localparam logic [1:0] RATE_2M      = 2'h0;
  localparam logic [1:0] RATE_8M      = 2'h2;
  localparam int         NUM_LINES    = 32;
endpackage

// *** ccd_core_model.sv ***
module ccd_core_model (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic disconnect_all,
  input  wire logic bidir_connect,
  input  wire logic fail_req,
  output logic      conn_ready,
  output logic      ref_fail
);
  // ****************************************
  // switching core stand-in
  // ****************************************
  logic [1:0] busy_r;
  logic [1:0] busy_nxt;
  // each disconnect_all or bidir_connect pulse keeps the core busy, so the host has to poll
  always_comb begin
    busy_nxt = busy_r;
    if (disconnect_all || bidir_connect) begin
      busy_nxt = 2'h2;
    end else if (busy_r != 2'h0) begin
      busy_nxt = busy_r - 2'h1;
    end
  end
  // failure follows the request one cycle late, like a clock monitor
  always_ff @(posedge core_clk) begin
    busy_r   <= sys_rst ? 2'h0 : busy_nxt;
    ref_fail <= sys_rst ? 1'b0 : fail_req;
  end
  assign conn_ready = (busy_r == 2'h0);
endmodule

// *** ccd_decoder_assertions.sv ***
module ccd_checker
  import ccd_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  input wire logic        h_mode,
  input wire logic        ref_fail,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        disconnect_all,
  input wire logic        bidir_connect,
  input wire logic        bidir_const_delay,
  input wire logic        dump_en,
  input wire logic        pcm_clk_en,
  input wire logic [2:0]  pcm_clk_rate,
  input wire logic [1:0]  backplane_out_sel,
  input wire logic [1:0]  fallback_mode,
  input wire logic        pll_src_fail,
  input wire logic        ref_src_fail,
  input wire logic [63:0] bp_line_rates
);
  // ****************************************
  // command strobes
  // ****************************************
  wire logic       wr_clk = clk_en && reg_wr && reg_addr == OFS_CLK_CMD;
  wire logic       wr_con = clk_en && reg_wr && reg_addr == OFS_CONN_CMD;
  wire logic [3:0] code   = reg_wdata[3:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_DISC: assert property (
    wr_con |=> disconnect_all == ($past(code) == CN_DISC_ALL))
    else $error("disconnect pulse wrong");
  AST_ONCE: assert property (
    disconnect_all || bidir_connect |-> $past(wr_con))
    else $error("pulse without a write");
  AST_BIDIR: assert property (
    wr_con && code == CN_BIDIR
    |=> bidir_connect && bidir_const_delay == $past(reg_wdata[4]))
    else $error("bidirectional connect wrong");
  AST_DUMP: assert property (
    wr_con && code == CN_DUMP |=> dump_en == $past(reg_wdata[4]))
    else $error("dump enable wrong");
  AST_RDIDLE: assert property (
    clk_en && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  AST_PCM: assert property (
    wr_clk && code == CC_PCM_CLK && reg_wdata[6:4] inside {[3'h1:3'h4]}
    |=> pcm_clk_en && pcm_clk_rate == $past(reg_wdata[6:4]))
    else $error("pcm clock setting wrong");
  AST_MODE: assert property (
    wr_clk && code == CC_BP_OUT && !h_mode |=> $stable(backplane_out_sel))
    else $error("backplane output changed in wrong mode");
  AST_FAIL: assert property (
    clk_en |=> ref_src_fail == pll_src_fail && ref_src_fail ==
      ($past(ref_fail) && $past(fallback_mode) != 2'h0))
    else $error("failure flags wrong");
  AST_ALL8: assert property (
    wr_clk && code == CC_RATE_BP && reg_wdata[5:4] == 2'h3
    |=> bp_line_rates == {32{RATE_8M}})
    else $error("all lines rate wrong");
  COV_BIDIR: cover property (wr_con && code == CN_BIDIR);
  COV_PCM: cover property (wr_clk && code == CC_PCM_CLK);
  COV_FAIL: cover property (pll_src_fail);
endmodule
bind ccd_decoder ccd_checker u_chk (
  .core_clk, .sys_rst, .clk_en, .h_mode, .ref_fail, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .disconnect_all,
  .bidir_connect, .bidir_const_delay, .dump_en, .pcm_clk_en,
  .pcm_clk_rate, .backplane_out_sel, .fallback_mode, .pll_src_fail,
  .ref_src_fail, .bp_line_rates
);

// *** clock_config_command_decoder_test.sv ***
module clock_config_command_decoder_test
  import ccd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // bench signals
  // ****************************************
  logic        core_clk, sys_rst, clk_en, h_mode, fail_req, reg_wr, reg_rd;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        conn_ready, ref_fail, disconnect_all, bidir_connect;
  logic        bidir_const_delay, dump_en, pcm_clk_en, pcm_clk_out;
  logic        backplane_master, compat_first_en, compat_second_en;
  logic        netref_two_inv, refallback_en, phase_align_en;
  logic        pll_src_fail, ref_src_fail, ts_read_req, ts_read_output;
  logic [3:0]  primary_ref_sel, secondary_ref_sel, slave_src_sel;
  logic [2:0]  secondary_ref_freq;
  logic        special_prog;
  logic [7:0]  special_cfg;
  logic [2:0]  primary_ref_freq, pcm_clk_rate, netref_two_sel;
  logic [1:0]  backplane_out_sel, serial_bus_sel, netref_two_freq;
  logic [1:0]  fallback_mode;
  logic [63:0] local_in_rates, local_out_rates, bp_line_rates;
  int          bad_count, samples_checked;
  ccd_decoder dut (
    .core_clk, .sys_rst, .clk_en, .h_mode, .conn_ready, .ref_fail,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .source_port_address(), .input_slot_address(),
    .destination_port_address(), .output_slot_address(),
    .backplane_master, .primary_ref_sel, .primary_ref_freq,
    .secondary_ref_sel, .secondary_ref_freq, .slave_src_sel,
    .special_prog, .special_cfg, .backplane_out_sel, .pcm_clk_en,
    .pcm_clk_rate, .pcm_clk_out, .compat_first_en, .compat_second_en,
    .serial_bus_sel, .netref_one_sel(), .netref_one_inv(),
    .netref_one_freq(), .netref_two_sel, .netref_two_inv,
    .netref_two_freq, .fallback_mode, .refallback_en, .phase_align_en,
    .pll_src_fail, .ref_src_fail, .local_in_rates, .local_out_rates,
    .bp_line_rates, .disconnect_all, .bidir_connect, .bidir_const_delay,
    .dump_en, .ts_read_req, .ts_read_output
  );
  ccd_core_model u_core (
    .core_clk, .sys_rst, .disconnect_all, .bidir_connect, .fail_req,
    .conn_ready, .ref_fail
  );
  always #5 core_clk = ~core_clk;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle strobes; results are sampled just after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // bounded poll: a core that never frees up must not hang the run
  task automatic wr_conn(input logic [7:0] d);
    int n;
    // the core answers a pulse one edge late, so wait before polling
    @(posedge core_clk);
    #1 n = 0;
    while (conn_ready !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(conn_ready, 1'b1);
    wr(OFS_CONN_CMD, d);
  endtask
  task automatic t_reset();
    chk(fallback_mode, 2'h0);
    chk(local_in_rates, 64'h0);
    rd(OFS_CLK_CMD, RST_BYTE);
    rd(8'h30, 8'h00);
    wr(OFS_CLK_CMD, 8'hF0);
    rd(OFS_CLK_CMD, 8'hF0);
    chk(pcm_clk_en, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_conn();
    wr_conn(8'h19);
    chk({bidir_connect, bidir_const_delay}, 2'h3);
    @(posedge core_clk);
    #1 chk(bidir_connect, 1'b0);
    wr_conn(8'h08);
    chk(disconnect_all, 1'b1);
    wr_conn(8'h1A);
    chk(dump_en, 1'b1);
    rd(OFS_STATUS, 8'h03);
    wr_conn(8'h0A);
    chk(dump_en, 1'b0);
    $display("test connection done");
  endtask
  task automatic t_primary();
    @(posedge core_clk) h_mode <= 1'b1;
    wr(OFS_GEN_IN1, 8'h05);
    wr(OFS_CLK_CMD, 8'h32);
    chk({primary_ref_sel, primary_ref_freq}, 7'h1D);
    wr(OFS_GEN_IN1, 8'h02);
    wr(OFS_CLK_CMD, 8'h72);
    chk({primary_ref_sel, primary_ref_freq}, 7'h3D);
    wr(OFS_CLK_CMD, 8'h92);
    chk(primary_ref_sel, 4'h7);
    @(posedge core_clk) h_mode <= 1'b0;
    wr(OFS_CLK_CMD, 8'h12);
    chk({primary_ref_sel, primary_ref_freq}, 7'h0A);
    wr(OFS_CLK_CMD, 8'h32);
    chk(primary_ref_sel, 4'h1);
    wr(OFS_CLK_CMD, 8'h15);
    chk(backplane_out_sel, 2'h0);
    @(posedge core_clk) h_mode <= 1'b1;
    wr(OFS_CLK_CMD, 8'h15);
    chk(backplane_out_sel, 2'h1);
    $display("test primary done");
  endtask
  task automatic t_pcm();
    logic [2:0] er;
    er = 3'h0;
    for (int q = 0; q < 8; q++) begin
      wr(OFS_CLK_CMD, {1'b1, q[2:0], CC_PCM_CLK});
      if (q >= 1 && q <= 4) er = q[2:0];
      chk(pcm_clk_rate, er);
    end
    chk({pcm_clk_en, pcm_clk_out}, 2'h3);
    $display("test pcm done");
  endtask
  task automatic t_fall();
    wr(OFS_CLK_CMD, 8'hDA);
    chk(fallback_mode, 2'h1);
    chk({refallback_en, phase_align_en}, 2'h3);
    wr(OFS_CLK_CMD, 8'h11); // master only while h_mode is high
    chk(backplane_master, 1'b1);
    @(posedge core_clk) fail_req <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk({pll_src_fail, ref_src_fail}, 2'h3);
    wr(OFS_CLK_CMD, 8'h8A);
    repeat (2) @(posedge core_clk);
    #1 chk({pll_src_fail, ref_src_fail}, 2'h0);
    @(posedge core_clk) fail_req <= 1'b0;
    $display("test fallback done");
  endtask
  task automatic t_rate();
    wr(OFS_SRC_PORT, 8'h05);
    wr(OFS_DST_PORT, 8'h07);
    wr(OFS_CLK_CMD, 8'hEB);
    chk(local_in_rates[11:8], {RATE_8M, RATE_2M});
    chk(local_out_rates[15:14], RATE_8M);
    wr(OFS_CLK_CMD, 8'h1C);
    chk(bp_line_rates[11:10], 2'h1);
    wr(OFS_CLK_CMD, 8'h3C);
    chk(bp_line_rates, {32{RATE_8M}});
    $display("test rate done");
  endtask
  task automatic t_misc();
    wr(OFS_CLK_CMD, 8'hD7);
    chk({compat_first_en, compat_second_en, serial_bus_sel}, 4'hB);
    wr(OFS_CLK_CMD, 8'h99);
    chk({netref_two_sel, netref_two_inv, netref_two_freq}, 6'h26);
    wr(OFS_CLK_CMD, 8'h1D);
    chk({ts_read_req, ts_read_output}, 2'h3);
    $display("test misc done");
  endtask
  task automatic t_slave();
    wr(OFS_CLK_CMD, 8'h63);
    chk({secondary_ref_sel, secondary_ref_freq}, 7'h32);
    wr(OFS_CLK_CMD, 8'hF3);
    chk({special_prog, secondary_ref_sel}, 5'h16);
    wr(OFS_CLK_CMD, 8'h24);
    chk(slave_src_sel, 4'h0);
    wr(OFS_CLK_CMD, 8'h94);
    chk(slave_src_sel, 4'h9);
    wr(OFS_GEN_IN1, 8'hA5);
    wr(OFS_CLK_CMD, 8'hF4);
    chk({special_prog, special_cfg}, 9'h0A5);
    // a write while the enable is low must be lost
    @(posedge core_clk) clk_en <= 1'b0;
    wr(OFS_CLK_CMD, 8'h05);
    chk(backplane_out_sel, 2'h1);
    @(posedge core_clk) clk_en <= 1'b1;
    $display("test slave done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // main sequence; clk_en stays high so every write is taken, except the one t_slave makes with clk_en low
  initial begin
    {core_clk, h_mode, fail_req, reg_wr, reg_rd} = 5'h00;
    {reg_addr, reg_wdata} = 16'h0000;
    {clk_en, sys_rst} = 2'h3;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1 t_reset();
    t_conn();
    t_primary();
    t_pcm();
    t_fall();
    t_rate();
    t_misc();
    t_slave();
    report_and_stop();
  end
  // the tests need well under 2000 cycles
  initial begin
    #20000;
    bad_count++;
    report_and_stop();
  end
endmodule
